// ==== hdl/cpsc_top.sv ====
// compartment parameter-store controller: startup load, mirroring of saved
// parameter sets, store-expected flag, protection commands and events
// assumes an APB master on mclk and a store answering each request once
// by a storeDone pulse; store inputs synchronous to mclk
//
// Summary of operation
// - every saved parameter set is also written to a connected store
// - a successful store write raises the programmed event
// - a store found at startup is loaded over the unit parameters
// - loading from the store sets the store-expected flag
// - expected but missing store at startup trips and flashes the fault lamp
// - trip reset refused until store present or expected flag cleared
// - saving a set with expected cleared turns the mechanism off
// - factory reset without store turns the mechanism off
// - full protection on locks store, refuses changes, raises its event
// - full protection off allows store and unit changes again
// - id protection accepts a set only with identical id data
// - id protection on raises its own event
// - id protection off releases the stored id data
// - clear erases the store and raises the cleared event
// - empty store at startup gives a parameter fault and flashing lamp
// - parameter fault may be acknowledged only after unit and store rewritten
// - a save refused by protection raises the denied event
// - a successful startup load raises the read-in event
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module cpsc_top
	import cpsc_pkg::*;
#(
	parameter int BLINK_HALF_CYC = CPSC_BLINK_HALF_CYC
)
(
	input  wire logic                mclk,
	input  wire logic                rstn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                storePresent,
	input  wire logic                storeEmpty,
	input  wire logic                storeFullWp,
	input  wire logic                storeIdWp,
	input  wire logic [CPSC_PW-1:0]  storeRdParam,
	input  wire logic [CPSC_IW-1:0]  storeRdId,
	input  wire logic                storeDone,
	input  wire logic                storeOk,
	output logic                     storeReq,
	output logic      [2:0]          storeOp,
	output logic      [CPSC_PW-1:0]  storeWrParam,
	output logic      [CPSC_IW-1:0]  storeWrId,
	input  wire logic                nvExpectedIn,
	output logic                     nvExpectedOut,
	output logic      [CPSC_PW-1:0]  unitParam,
	output logic      [CPSC_IW-1:0]  unitId,
	output logic                     cfgTrip,
	output logic                     paramFault,
	output logic                     faultLed,
	output logic                     irq
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic regHit(input logic [7:0] a);
		case (a)
			CPSC_OFF_CFG, CPSC_OFF_CMD, CPSC_OFF_PSTAGE, CPSC_OFF_ISTAGE,
			CPSC_OFF_PACT, CPSC_OFF_IACT, CPSC_OFF_STATUS, CPSC_OFF_EVENT,
			CPSC_OFF_MASK: regHit = 1'b1;
			default:       regHit = 1'b0;
		endcase
	endfunction

	function automatic logic wrHit(input logic [7:0] a, input logic [7:0] off,
		input logic acc, input logic wr);
		wrHit = acc && wr && (a == off);
	endfunction

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic                   apbAcc;
	logic                   cmdWe;
	logic [CPSC_NUM_EV-1:0] evSet;
	logic [CPSC_NUM_EV-1:0] evFlags;
	logic [CPSC_NUM_EV-1:0] evMask;

	cpsc_state_type    state_q,     state_d;
	cpsc_op_type       op_q,        op_d;
	logic              expected_q,  expected_d;
	logic              cfgStage_q,  cfgStage_d;
	logic [CPSC_PW-1:0] pStage_q,   pStage_d;
	logic [CPSC_IW-1:0] iStage_q,   iStage_d;
	logic [CPSC_PW-1:0] pAct_q,     pAct_d;
	logic [CPSC_IW-1:0] iAct_q,     iAct_d;
	logic              cfgTrip_q,   cfgTrip_d;
	logic              pFault_q,    pFault_d;
	logic              repaired_q,  repaired_d;
	logic              req_q,       req_d;
	logic [CPSC_PW-1:0] wrParam_q,  wrParam_d;
	logic [CPSC_IW-1:0] wrId_q,     wrId_d;
	logic [31:0]       prdata_q,    prdata_d;
	logic [CPSC_BLINK_W-1:0] blink_q, blink_d;
	logic              lamp_q,      lamp_d;

	assign apbAcc = psel && penable;
	assign cmdWe  = wrHit(paddr, CPSC_OFF_CMD, apbAcc, pwrite);

	// ---------------------------------------------------------------
	// control sequencer
	// ---------------------------------------------------------------
	always_comb begin
		state_d    = state_q;
		op_d       = op_q;
		expected_d = expected_q;
		cfgStage_d = cfgStage_q;
		pStage_d   = pStage_q;
		iStage_d   = iStage_q;
		pAct_d     = pAct_q;
		iAct_d     = iAct_q;
		cfgTrip_d  = cfgTrip_q;
		pFault_d   = pFault_q;
		repaired_d = repaired_q;
		req_d      = 1'b0;
		wrParam_d  = wrParam_q;
		wrId_d     = wrId_q;
		evSet      = '0;

		if (wrHit(paddr, CPSC_OFF_CFG, apbAcc, pwrite)) begin
			cfgStage_d = pwdata[0];
		end
		if (wrHit(paddr, CPSC_OFF_PSTAGE, apbAcc, pwrite)) begin
			pStage_d = pwdata;
		end
		if (wrHit(paddr, CPSC_OFF_ISTAGE, apbAcc, pwrite)) begin
			iStage_d = pwdata[CPSC_IW-1:0];
		end

		case (state_q)
			CPSC_BOOT: begin
				// retained flag taken after reset release
				expected_d = nvExpectedIn;
				if (storePresent) begin
					op_d    = CPSC_OP_READ;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else begin
					if (nvExpectedIn) begin
						cfgTrip_d                = 1'b1;
						evSet[CPSC_EV_CFG_TRIP] = 1'b1;
					end
					state_d = CPSC_RUN;
				end
			end

			CPSC_WAIT: begin
				if (storeDone) begin
					state_d = CPSC_RUN;
					case (op_q)
						CPSC_OP_READ: begin
							if (storeEmpty || !storeOk) begin
								pFault_d                    = 1'b1;
								repaired_d                  = 1'b0;
								evSet[CPSC_EV_PARAM_FAULT] = 1'b1;
							end else begin
								pAct_d                 = storeRdParam;
								iAct_d                 = storeRdId;
								expected_d             = 1'b1;
								evSet[CPSC_EV_READIN] = 1'b1;
							end
						end
						CPSC_OP_WRITE: begin
							if (storeOk) begin
								evSet[CPSC_EV_PROGRAMMED] = 1'b1;
								repaired_d                = 1'b1;
							end
						end
						CPSC_OP_WP_ON: begin
							evSet[CPSC_EV_WP] = storeOk;
						end
						CPSC_OP_IDWP_ON: begin
							evSet[CPSC_EV_IDWP] = storeOk;
						end
						CPSC_OP_CLEAR: begin
							evSet[CPSC_EV_CLEARED] = storeOk;
						end
						default: begin
						end
					endcase
				end
			end

			CPSC_RUN: begin
				// one command per write, lowest bit first; ignored while busy
				if (cmdWe && pwdata[CPSC_CMD_SAVE]) begin
					if (storePresent && storeFullWp) begin
						evSet[CPSC_EV_DENIED] = 1'b1;
					end else if (storePresent && storeIdWp && iStage_q != storeRdId) begin
						evSet[CPSC_EV_DENIED] = 1'b1;
					end else begin
						pAct_d     = pStage_q;
						iAct_d     = iStage_q;
						expected_d = cfgStage_q;
						if (storePresent) begin
							wrParam_d = pStage_q;
							wrId_d    = iStage_q;
							op_d      = CPSC_OP_WRITE;
							req_d     = 1'b1;
							state_d   = CPSC_WAIT;
						end
					end
				end else if (cmdWe && pwdata[CPSC_CMD_WP_ON] && storePresent) begin
					op_d    = CPSC_OP_WP_ON;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else if (cmdWe && pwdata[CPSC_CMD_WP_OFF] && storePresent) begin
					op_d    = CPSC_OP_WP_OFF;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else if (cmdWe && pwdata[CPSC_CMD_IDWP_ON] && storePresent) begin
					op_d    = CPSC_OP_IDWP_ON;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else if (cmdWe && pwdata[CPSC_CMD_IDWP_OFF] && storePresent) begin
					op_d    = CPSC_OP_IDWP_OFF;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else if (cmdWe && pwdata[CPSC_CMD_CLEAR] && storePresent) begin
					op_d    = CPSC_OP_CLEAR;
					req_d   = 1'b1;
					state_d = CPSC_WAIT;
				end else if (cmdWe && pwdata[CPSC_CMD_FACTORY] && !storePresent) begin
					pAct_d     = CPSC_PARAM_RST;
					iAct_d     = CPSC_ID_RST;
					expected_d = 1'b0;
				end else if (cmdWe && pwdata[CPSC_CMD_ACK]) begin
					if (storePresent || !expected_q) begin
						cfgTrip_d = 1'b0;
					end
					if (repaired_q) begin
						pFault_d   = 1'b0;
						repaired_d = 1'b0;
					end
				end
			end

			default: begin
				state_d = CPSC_BOOT;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_q    <= CPSC_BOOT;
			op_q       <= CPSC_OP_READ;
			expected_q <= 1'b0;
			cfgStage_q <= 1'b0;
			pStage_q   <= CPSC_PARAM_RST;
			iStage_q   <= CPSC_ID_RST;
			pAct_q     <= CPSC_PARAM_RST;
			iAct_q     <= CPSC_ID_RST;
			cfgTrip_q  <= 1'b0;
			pFault_q   <= 1'b0;
			repaired_q <= 1'b0;
			req_q      <= 1'b0;
			wrParam_q  <= CPSC_PARAM_RST;
			wrId_q     <= CPSC_ID_RST;
		end else begin
			state_q    <= state_d;
			op_q       <= op_d;
			expected_q <= expected_d;
			cfgStage_q <= cfgStage_d;
			pStage_q   <= pStage_d;
			iStage_q   <= iStage_d;
			pAct_q     <= pAct_d;
			iAct_q     <= iAct_d;
			cfgTrip_q  <= cfgTrip_d;
			pFault_q   <= pFault_d;
			repaired_q <= repaired_d;
			req_q      <= req_d;
			wrParam_q  <= wrParam_d;
			wrId_q     <= wrId_d;
		end
	end

	// ---------------------------------------------------------------
	// fault lamp flashing
	// ---------------------------------------------------------------
	always_comb begin
		blink_d = blink_q;
		lamp_d  = 1'b0;
		if (cfgTrip_q || pFault_q) begin
			lamp_d = lamp_q;
			if (blink_q == CPSC_BLINK_W'(BLINK_HALF_CYC - 1)) begin
				blink_d = '0;
				lamp_d  = !lamp_q;
			end else begin
				blink_d = blink_q + 1'b1;
			end
		end else begin
			blink_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			blink_q <= '0;
			lamp_q  <= 1'b0;
		end else begin
			blink_q <= blink_d;
			lamp_q  <= lamp_d;
		end
	end

	// ---------------------------------------------------------------
	// APB read data, captured in the setup cycle
	// ---------------------------------------------------------------
	always_comb begin
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			prdata_d = '0;
			case (paddr)
				CPSC_OFF_CFG:    prdata_d[0] = cfgStage_q;
				CPSC_OFF_PSTAGE: prdata_d = pStage_q;
				CPSC_OFF_ISTAGE: prdata_d[CPSC_IW-1:0] = iStage_q;
				CPSC_OFF_PACT:   prdata_d = pAct_q;
				CPSC_OFF_IACT:   prdata_d[CPSC_IW-1:0] = iAct_q;
				CPSC_OFF_STATUS: begin
					prdata_d[CPSC_ST_EXPECTED] = expected_q;
					prdata_d[CPSC_ST_BUSY]     = (state_q != CPSC_RUN);
					prdata_d[CPSC_ST_CFGTRIP]  = cfgTrip_q;
					prdata_d[CPSC_ST_PFAULT]   = pFault_q;
					prdata_d[CPSC_ST_PRESENT]  = storePresent;
					prdata_d[CPSC_ST_FULLWP]   = storeFullWp;
					prdata_d[CPSC_ST_IDWP]     = storeIdWp;
					prdata_d[CPSC_ST_REPAIRED] = repaired_q;
				end
				CPSC_OFF_EVENT:  prdata_d[CPSC_NUM_EV-1:0] = evFlags;
				CPSC_OFF_MASK:   prdata_d[CPSC_NUM_EV-1:0] = evMask;
				default:         prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// ---------------------------------------------------------------
	// event flags and interrupt
	// ---------------------------------------------------------------
	cpsc_event_bank u_events (
		.mclk    (mclk),
		.rstn    (rstn),
		.evSet   (evSet),
		.clrWe   (wrHit(paddr, CPSC_OFF_EVENT, apbAcc, pwrite)),
		.maskWe  (wrHit(paddr, CPSC_OFF_MASK, apbAcc, pwrite)),
		.wrData  (pwdata[CPSC_NUM_EV-1:0]),
		.evFlags (evFlags),
		.evMask  (evMask),
		.irq     (irq)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata        = prdata_q;
	assign pready        = 1'b1;
	assign pslverr       = apbAcc && !regHit(paddr);
	assign storeReq      = req_q;
	assign storeOp       = op_q;
	assign storeWrParam  = wrParam_q;
	assign storeWrId     = wrId_q;
	assign nvExpectedOut = expected_q;
	assign unitParam     = pAct_q;
	assign unitId        = iAct_q;
	assign cfgTrip       = cfgTrip_q;
	assign paramFault    = pFault_q;
	assign faultLed      = lamp_q;

endmodule

// ==== inc/cpsc_pkg.sv ====
// constants and types for the compartment parameter-store controller
// assumes a 10 MHz mclk and an 8-bit APB byte address
package cpsc_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] CPSC_OFF_CFG     = 8'h00;
	localparam logic [7:0] CPSC_OFF_CMD     = 8'h04;
	localparam logic [7:0] CPSC_OFF_PSTAGE  = 8'h08;
	localparam logic [7:0] CPSC_OFF_ISTAGE  = 8'h0c;
	localparam logic [7:0] CPSC_OFF_PACT    = 8'h10;
	localparam logic [7:0] CPSC_OFF_IACT    = 8'h14;
	localparam logic [7:0] CPSC_OFF_STATUS  = 8'h18;
	localparam logic [7:0] CPSC_OFF_EVENT   = 8'h1c;
	localparam logic [7:0] CPSC_OFF_MASK    = 8'h20;

	// ---------------------------------------------------------------
	// command register bit positions
	// ---------------------------------------------------------------
	localparam int CPSC_CMD_SAVE     = 0;
	localparam int CPSC_CMD_WP_ON    = 1;
	localparam int CPSC_CMD_WP_OFF   = 2;
	localparam int CPSC_CMD_IDWP_ON  = 3;
	localparam int CPSC_CMD_IDWP_OFF = 4;
	localparam int CPSC_CMD_CLEAR    = 5;
	localparam int CPSC_CMD_FACTORY  = 6;
	localparam int CPSC_CMD_ACK      = 7;

	// ---------------------------------------------------------------
	// event bit positions (event flags, mask and W1C share this layout)
	// ---------------------------------------------------------------
	localparam int CPSC_NUM_EV         = 8;
	localparam int CPSC_EV_PROGRAMMED  = 0;
	localparam int CPSC_EV_READIN      = 1;
	localparam int CPSC_EV_WP          = 2;
	localparam int CPSC_EV_IDWP        = 3;
	localparam int CPSC_EV_CLEARED     = 4;
	localparam int CPSC_EV_DENIED      = 5;
	localparam int CPSC_EV_CFG_TRIP    = 6;
	localparam int CPSC_EV_PARAM_FAULT = 7;

	// ---------------------------------------------------------------
	// status register bit positions
	// ---------------------------------------------------------------
	localparam int CPSC_ST_EXPECTED = 0;
	localparam int CPSC_ST_BUSY     = 1;
	localparam int CPSC_ST_CFGTRIP  = 2;
	localparam int CPSC_ST_PFAULT   = 3;
	localparam int CPSC_ST_PRESENT  = 4;
	localparam int CPSC_ST_FULLWP   = 5;
	localparam int CPSC_ST_IDWP     = 6;
	localparam int CPSC_ST_REPAIRED = 7;

	// ---------------------------------------------------------------
	// widths and values after reset
	// ---------------------------------------------------------------
	localparam int          CPSC_PW        = 32;
	localparam int          CPSC_IW        = 16;
	localparam logic [31:0] CPSC_PARAM_RST = 32'h00000000;
	localparam logic [15:0] CPSC_ID_RST    = 16'h0000;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CPSC_CLK_PERIOD_NS  = 100;
	localparam int CPSC_BLINK_HALF_MS  = 500;
	localparam int CPSC_BLINK_HALF_CYC = CPSC_BLINK_HALF_MS * 1000000 / CPSC_CLK_PERIOD_NS;
	localparam int CPSC_BLINK_W        = 23;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CPSC_OP_READ     = 3'h0,
		CPSC_OP_WRITE    = 3'h1,
		CPSC_OP_WP_ON    = 3'h2,
		CPSC_OP_WP_OFF   = 3'h3,
		CPSC_OP_IDWP_ON  = 3'h4,
		CPSC_OP_IDWP_OFF = 3'h5,
		CPSC_OP_CLEAR    = 3'h6
	} cpsc_op_type;

	typedef enum logic [1:0] {
		CPSC_BOOT = 2'b00,
		CPSC_WAIT = 2'b01,
		CPSC_RUN  = 2'b11
	} cpsc_state_type;

endpackage

// ==== hdl/cpsc_event_bank.sv ====
// sticky event flags, their mask and the level interrupt
// assumes set pulses and write strobes synchronous to mclk
`timescale 1ns/1ns
module cpsc_event_bank
	import cpsc_pkg::*;
(
	input  wire logic                   mclk,
	input  wire logic                   rstn,
	input  wire logic [CPSC_NUM_EV-1:0] evSet,
	input  wire logic                   clrWe,
	input  wire logic                   maskWe,
	input  wire logic [CPSC_NUM_EV-1:0] wrData,
	output logic      [CPSC_NUM_EV-1:0] evFlags,
	output logic      [CPSC_NUM_EV-1:0] evMask,
	output logic                        irq
);

	logic [CPSC_NUM_EV-1:0] flags_q;
	logic [CPSC_NUM_EV-1:0] flags_d;
	logic [CPSC_NUM_EV-1:0] mask_q;
	logic [CPSC_NUM_EV-1:0] mask_d;
	logic                   irq_q;
	logic                   irq_d;

	// a new event wins over a write-one-to-clear in the same cycle
	always_comb begin
		flags_d = flags_q;
		mask_d  = mask_q;
		if (clrWe) begin
			flags_d = flags_d & ~wrData;
		end
		flags_d = flags_d | evSet;
		if (maskWe) begin
			mask_d = wrData;
		end
		irq_d = |(flags_d & mask_d);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			flags_q <= '0;
			mask_q  <= '0;
			irq_q   <= 1'b0;
		end else begin
			flags_q <= flags_d;
			mask_q  <= mask_d;
			irq_q   <= irq_d;
		end
	end

	assign evFlags = flags_q;
	assign evMask  = mask_q;
	assign irq     = irq_q;

endmodule

// ==== verification/cpsc_top_properties.sv ====
// concurrent checks on the store port and fault outputs of cpsc_top
// assumes a bind into cpsc_top and the single mclk domain
`timescale 1ns/1ns
module cpsc_top_properties
	import cpsc_pkg::*;
#(
	parameter int BLINK_HALF_CYC = 4
)
(
	input wire logic               mclk,
	input wire logic               rstn,
	input wire logic               storePresent,
	input wire logic               storeEmpty,
	input wire logic [CPSC_PW-1:0] storeRdParam,
	input wire logic               storeDone,
	input wire logic               storeOk,
	input wire logic               storeReq,
	input wire logic [2:0]         storeOp,
	input wire logic [CPSC_PW-1:0] storeWrParam,
	input wire logic [CPSC_IW-1:0] storeWrId,
	input wire logic               nvExpectedIn,
	input wire logic               nvExpectedOut,
	input wire logic [CPSC_PW-1:0] unitParam,
	input wire logic [CPSC_IW-1:0] unitId,
	input wire logic               cfgTrip,
	input wire logic               paramFault,
	input wire logic               faultLed
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// good store write seen during the fault
	logic rewr_q;
	logic rewr_d;
	always_comb begin
		rewr_d = rewr_q;
		if (storeDone && storeOk && storeOp == CPSC_OP_WRITE)
			rewr_d = 1'b1;
		else if (!paramFault)
			rewr_d = 1'b0;
	end
	always_ff @(posedge mclk) begin
		rewr_q <= rstn ? rewr_d : 1'b0;
	end

	sequence bootSeq;
		rstn && !$past(rstn);
	endsequence
	sequence loadSeq;
		storeDone && storeOk && storeOp == CPSC_OP_READ && storePresent && !storeEmpty;
	endsequence
	sequence faultSeq;
		(cfgTrip || paramFault)[*8];
	endsequence

	AST_MIRROR: assert property (storeReq && storeOp == CPSC_OP_WRITE |->
		storeWrParam == unitParam && storeWrId == unitId) else $error("bad mirror");
	AST_BOOT_READ: assert property (bootSeq ##0 storePresent |->
		##[1:3] storeReq && storeOp == CPSC_OP_READ) else $error("no boot read");
	AST_LOAD: assert property (loadSeq |-> ##[1:2] unitParam == storeRdParam)
		else $error("not loaded");
	AST_EXPECT: assert property (loadSeq |-> ##[1:2] nvExpectedOut)
		else $error("no expected");
	AST_TRIP_BOOT: assert property (bootSeq ##0 nvExpectedIn && !storePresent |->
		##[1:3] cfgTrip) else $error("no trip");
	AST_BLINK: assert property (faultSeq |-> faultLed != $past(faultLed, BLINK_HALF_CYC))
		else $error("no flash");
	AST_DARK: assert property ((!cfgTrip && !paramFault)[*2] |-> !faultLed)
		else $error("lamp lit");
	AST_EMPTY: assert property (storeDone && storeOp == CPSC_OP_READ &&
		(storeEmpty || !storeOk) |-> ##[1:2] paramFault) else $error("no fault");
	AST_TRIP_HOLD: assert property ($fell(cfgTrip) |->
		$past(storePresent) || !$past(nvExpectedOut)) else $error("early trip reset");
	AST_PF_HOLD: assert property ($fell(paramFault) |-> rewr_q)
		else $error("early ack");
endmodule

bind cpsc_top cpsc_top_properties #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) chk (.mclk, .rstn,
	.storePresent, .storeEmpty, .storeRdParam, .storeDone, .storeOk, .storeReq, .storeOp,
	.storeWrParam, .storeWrId, .nvExpectedIn, .nvExpectedOut, .unitParam, .unitId, .cfgTrip,
	.paramFault, .faultLed);

// ==== verification/cpsc_store_model.sv ====
// behavioural parameter store on the far side of the store port
// assumes one request at a time; the bench sets the answer lag per request
`timescale 1ns/1ns
module cpsc_store_model
	import cpsc_pkg::*;
#(
	parameter logic [CPSC_PW-1:0] INIT_PARAM = 32'h5a5a0f0f,
	parameter logic [CPSC_IW-1:0] INIT_ID    = 16'h0c3a
)
(
	input  wire logic               mclk,
	input  wire logic               present,
	input  wire logic [3:0]         lag,
	input  wire logic               storeReq,
	input  wire logic [2:0]         storeOp,
	input  wire logic [CPSC_PW-1:0] storeWrParam,
	input  wire logic [CPSC_IW-1:0] storeWrId,
	output logic                    storeEmpty,
	output logic                    storeFullWp,
	output logic                    storeIdWp,
	output logic      [CPSC_PW-1:0] storeRdParam,
	output logic      [CPSC_IW-1:0] storeRdId,
	output logic                    storeDone,
	output logic                    storeOk
);
	logic [CPSC_PW-1:0] memParam_q = INIT_PARAM;
	logic [CPSC_IW-1:0] memId_q    = INIT_ID;
	logic               empty_q    = 1'b0;
	logic               fullWp_q   = 1'b0;
	logic               idWp_q     = 1'b0;
	logic [2:0]         op_q       = 3'h0;
	int                 cnt_q      = 0;
	// unplugged lines show the inverse
	assign storeRdParam = present ? memParam_q : ~memParam_q;
	assign storeRdId    = present ? memId_q : ~memId_q;
	assign storeEmpty   = present && empty_q;
	assign storeFullWp  = present && fullWp_q;
	assign storeIdWp    = present && idWp_q;
	always @(posedge mclk) begin
		storeDone <= 1'b0;
		storeOk   <= 1'b0;
		if (storeReq) begin
			op_q  <= storeOp;
			cnt_q <= int'(lag) + 1;
		end else if (cnt_q == 1) begin
			cnt_q     <= 0;
			storeDone <= 1'b1;
			storeOk   <= !(op_q == CPSC_OP_WRITE && fullWp_q);
			case (op_q)
				CPSC_OP_WRITE: if (!fullWp_q) begin
					memParam_q <= storeWrParam;
					memId_q    <= storeWrId;
					empty_q    <= 1'b0;
				end
				CPSC_OP_WP_ON:    fullWp_q <= 1'b1;
				CPSC_OP_WP_OFF:   fullWp_q <= 1'b0;
				CPSC_OP_IDWP_ON:  idWp_q <= 1'b1;
				CPSC_OP_IDWP_OFF: idWp_q <= 1'b0;
				CPSC_OP_CLEAR: begin
					memParam_q <= '0;
					empty_q    <= 1'b1;
					fullWp_q   <= 1'b0;
					idWp_q     <= 1'b0;
				end
				default: ;
			endcase
		end else if (cnt_q > 1)
			cnt_q <= cnt_q - 1;
	end
endmodule

// ==== verification/compartment_param_store_control_bench.sv ====
// self-checking bench: APB master, behavioural store and expected values
// assumes cpsc_top, cpsc_store_model and the bound checker
`timescale 1ns/1ns
module compartment_param_store_control_bench
	import cpsc_pkg::*;
;
	localparam logic [31:0] INIT_P = 32'h5a5a0f0f;
	logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q, expP, storeRdParam, storeWrParam, unitParam;
	logic [15:0] expI, storeRdId, storeWrId, unitId;
	logic [3:0]  lag = 4'h0;
	logic [2:0]  storeOp;
	logic        present = 1'b1, nvExpIn = 1'b0, pready, pslverr, slvErr, storeEmpty;
	logic        storeFullWp, storeIdWp, storeDone, storeOk, storeReq, nvExpectedOut;
	logic        cfgTrip, paramFault, faultLed, irq;
	int          nFail = 0, numChecks = 0, cyc = 0;
	always #50 mclk = ~mclk;

	cpsc_top #(.BLINK_HALF_CYC(4)) uut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .storePresent(present), .storeEmpty, .storeFullWp,
		.storeIdWp, .storeRdParam, .storeRdId, .storeDone, .storeOk, .storeReq, .storeOp,
		.storeWrParam, .storeWrId, .nvExpectedIn(nvExpIn), .nvExpectedOut, .unitParam, .unitId,
		.cfgTrip, .paramFault, .faultLed, .irq);
	cpsc_store_model #(.INIT_PARAM(INIT_P)) model (.mclk, .present, .lag, .storeReq, .storeOp,
		.storeWrParam, .storeWrId, .storeEmpty, .storeFullWp, .storeIdWp, .storeRdParam,
		.storeRdId, .storeDone, .storeOk);

	task automatic completeRun;
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chkBit(input logic got, input logic exp);
		chkVal(32'(got), 32'(exp));
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		slvErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chkVal(q, e);
	endtask
	task automatic idle;
		do apb(1'b0, CPSC_OFF_STATUS, 32'h0); while (q[CPSC_ST_BUSY] !== 1'b0);
	endtask
	task automatic cmd(input int b);
		apb(1'b1, CPSC_OFF_CMD, 32'h1 << b);
		idle();
	endtask
	task automatic save(input logic [31:0] p, input logic [15:0] i, input logic c);
		apb(1'b1, CPSC_OFF_PSTAGE, p);
		apb(1'b1, CPSC_OFF_ISTAGE, {16'h0, i});
		apb(1'b1, CPSC_OFF_CFG, {31'h0, c});
		lag <= 4'($urandom % 8);
		cmd(CPSC_CMD_SAVE);
	endtask
	task automatic evChk(input int b);
		rdChk(CPSC_OFF_EVENT, b < 0 ? 32'h0 : 32'h1 << b);
		apb(1'b1, CPSC_OFF_EVENT, 32'hff);
	endtask
	task automatic doReset(input logic pr, input logic ne);
		rstn    <= 1'b0;
		present <= pr;
		nvExpIn <= ne;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		idle();
	endtask
	task automatic blinkChk;
		int t = 0;
		logic l;
		@(negedge mclk);
		l = faultLed;
		repeat (16) begin
			@(negedge mclk);
			t += int'(faultLed !== l);
			l = faultLed;
		end
		chkVal(32'(t), 32'd4);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			nFail++;
			completeRun();
		end
	end

	initial begin
		q = $urandom(32'hbebc17bc);
		doReset(1'b1, 1'b0);
		chkVal(unitParam, INIT_P);
		chkBit(nvExpectedOut, 1'b1);
		chkBit(irq, 1'b0);
		evChk(CPSC_EV_READIN);
		$display("test startup load done");
		apb(1'b1, CPSC_OFF_MASK, 32'h1 << CPSC_EV_PROGRAMMED);
		repeat (3) begin
			expP = $urandom;
			expI = 16'($urandom);
			save(expP, expI, 1'b1);
			chkVal(unitParam, expP);
			chkVal(model.memParam_q, expP);
			chkVal(32'(model.memId_q), 32'(expI));
			chkBit(irq, 1'b1);
			evChk(CPSC_EV_PROGRAMMED);
			repeat (2) @(negedge mclk);
			chkBit(irq, 1'b0);
		end
		$display("test mirrored save done");
		cmd(CPSC_CMD_IDWP_ON);
		evChk(CPSC_EV_IDWP);
		save(~expP, ~expI, 1'b1);
		evChk(CPSC_EV_DENIED);
		chkVal(unitParam, expP);
		expP = $urandom;
		save(expP, expI, 1'b1);
		evChk(CPSC_EV_PROGRAMMED);
		cmd(CPSC_CMD_IDWP_OFF);
		evChk(-1);
		expI = ~expI;
		save(expP, expI, 1'b1);
		chkVal(32'(unitId), 32'(expI));
		evChk(CPSC_EV_PROGRAMMED);
		apb(1'b0, 8'h24, 32'h0);
		chkBit(slvErr, 1'b1);
		chkVal(q, 32'h0);
		apb(1'b1, CPSC_OFF_PACT, ~expP);
		rdChk(CPSC_OFF_PACT, expP);
		rdChk(CPSC_OFF_CMD, 32'h0);
		$display("test id protection done");
		cmd(CPSC_CMD_WP_ON);
		evChk(CPSC_EV_WP);
		save(~expP, expI, 1'b1);
		evChk(CPSC_EV_DENIED);
		rdChk(CPSC_OFF_PACT, expP);
		cmd(CPSC_CMD_WP_OFF);
		save(~expP, expI, 1'b1);
		evChk(CPSC_EV_PROGRAMMED);
		chkVal(model.memParam_q, ~expP);
		$display("test full protection done");
		cmd(CPSC_CMD_CLEAR);
		evChk(CPSC_EV_CLEARED);
		doReset(1'b1, 1'b1);
		chkBit(paramFault, 1'b1);
		evChk(CPSC_EV_PARAM_FAULT);
		blinkChk();
		cmd(CPSC_CMD_ACK);
		chkBit(paramFault, 1'b1);
		save(expP, expI, 1'b1);
		cmd(CPSC_CMD_ACK);
		chkBit(paramFault, 1'b0);
		$display("test clear and empty start done");
		doReset(1'b0, 1'b1);
		chkBit(cfgTrip, 1'b1);
		evChk(CPSC_EV_CFG_TRIP);
		blinkChk();
		cmd(CPSC_CMD_ACK);
		chkBit(cfgTrip, 1'b1);
		save(expP, expI, 1'b0);
		chkBit(nvExpectedOut, 1'b0);
		evChk(-1);
		cmd(CPSC_CMD_ACK);
		chkBit(cfgTrip, 1'b0);
		$display("test missing store done");
		doReset(1'b1, 1'b0);
		chkBit(nvExpectedOut, 1'b1);
		present <= 1'b0;
		cmd(CPSC_CMD_FACTORY);
		chkBit(nvExpectedOut, 1'b0);
		$display("test factory reset done");
		completeRun();
	end
endmodule
